// [hw/dpc_pulse_counter.sv]
// Notes on behaviour
// R1: sixteen inputs counted in hardware, scan-free
// R2: pulses up to 5 kHz counted correctly
// R3: seven independent instances, index 0 to 6
// R4: pulse source any input 0 to 15
// R5: signed count always readable
// R6: valid while instance controls its channel
// R7: fault raises error flag and code
// R8: counting needs enable rise, then start
// R9: clear holds zero, ignores pulses
// R10: external clear on selected input rising edge
// R11: cyclic mode wraps to zero at limit
// R12: preload rise loads value, held while high
// R13: unused features stay inactive
// R14: clear select maps terminal groups
// R15: direction one counts up, zero down
`include "dpc_cfg.svh"
`default_nettype none
module dpc_pulse_counter #(
	parameter int NUM_CNT = 7,
	parameter int NUM_IN = 16
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// external pulse terminals
	input wire logic [NUM_IN-1:0] din_i,
	// axi4-lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt
	output logic irq_o
);
	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	// three index bits reach at most 8 instances; the source select is fixed at 4 bits
	if (NUM_CNT < 1 || NUM_CNT > 8) begin : g_chk_cnt
		$error("NUM_CNT must be 1 to 8");
	end
	if (NUM_IN != 16) begin : g_chk_in
		$error("NUM_IN must be 16");
	end

	// one 5 kHz period in system clocks; the counter itself needs only one edge per pulse
	localparam int PULSE_PERIOD_CYC = `DPC_CLK_HZ / `DPC_MAX_PULSE_HZ;
	if (PULSE_PERIOD_CYC < 4) begin : g_chk_rate
		$error("clock too slow for the pulse rate");
	end

	// ---------------------------------------------------------------
	// input synchroniser and edge detect
	// ---------------------------------------------------------------
	logic [NUM_IN-1:0] din_meta_r; // first stage, read only by second
	logic [NUM_IN-1:0] din_sync_r; // second stage
	logic [NUM_IN-1:0] din_prev_r; // delayed copy for edges
	wire [NUM_IN-1:0] din_rise = din_sync_r & ~din_prev_r;

	// R1: hardware synchroniser per input
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			din_meta_r <= '0;
			din_sync_r <= '0;
			din_prev_r <= '0;
		end else begin
			din_meta_r <= din_i;
			din_sync_r <= din_meta_r;
			din_prev_r <= din_sync_r;
		end
	end

	// R14: clear select, 0-7 then 10-17 terminals, both bank order 0..15
	function automatic logic [3:0] clr_term(input logic [3:0] sel);
		clr_term = sel;
	endfunction

	// ---------------------------------------------------------------
	// bus handshake decode
	// ---------------------------------------------------------------
	logic aw_held_r; // write address captured
	logic w_held_r; // write data captured
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	wire wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
	wire [2:0] wr_idx = awaddr_r[7:5];
	wire [4:0] wr_off = awaddr_r[4:0];
	wire wr_bank_ok = (awaddr_r[11:8] == 4'h0) && (int'(wr_idx) < NUM_CNT);
	wire [2:0] rd_idx = s_axi_araddr[7:5];
	wire [4:0] rd_off = s_axi_araddr[4:0];
	wire rd_bank_ok = (s_axi_araddr[11:8] == 4'h0) && (int'(rd_idx) < NUM_CNT);
	wire rd_fire = s_axi_arvalid && s_axi_arready;

	// byte-lane merge for a 32-bit register
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int b = 0; b < 4; b++) begin
			lane_merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction

	// ---------------------------------------------------------------
	// per-instance storage
	// ---------------------------------------------------------------
	logic [31:0] sel_r [NUM_CNT]; // [3:0] source, [7:4] clear input
	logic [31:0] ctrl_r [NUM_CNT];
	logic [31:0] cyc_r [NUM_CNT];
	logic [31:0] pre_r [NUM_CNT];
	logic [31:0] cnt_r [NUM_CNT];
	logic [2:0] ist_r [NUM_CNT]; // sticky events
	logic [2:0] imsk_r [NUM_CNT];
	logic [15:0] code_r [NUM_CNT];
	dpc_pkg::dpc_state_t st_r [NUM_CNT];
	logic [NUM_CNT-1:0] irq_vec;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
			// ---------------------------------------------------------------
			// one counter instance
			// ---------------------------------------------------------------
			wire wr_me = wr_fire && wr_bank_ok && (int'(wr_idx) == gi);
			wire [31:0] ctl = ctrl_r[gi];
			wire en = ctl[`DPC_CTRL_ENABLE];
			logic en_prev_r; // enable delayed, for rise
			logic pre_prev_r; // preload delayed, for rise
			// R13: unused features default zero and stay idle
			wire ext_en = ctl[`DPC_CTRL_EXT_CLR_EN];
			wire cyc_en = ctl[`DPC_CTRL_CYC_EN];
			wire pre_on = ctl[`DPC_CTRL_PRELOAD];
			// R4: source select mux
			wire pulse = din_rise[sel_r[gi][3:0]];
			wire ext_rise = ext_en && din_rise[clr_term(sel_r[gi][7:4])];
			wire run = (st_r[gi] == dpc_pkg::DPC_RUN);
			// R7: a zero cyclic limit is refused as a fault rather than counted against
			wire bad_cyc = cyc_en && ($signed(cyc_r[gi]) == 0);
			// R15: direction step
			wire [31:0] step = ctl[`DPC_CTRL_DIR_UP] ? 32'h0000_0001 : 32'hffff_ffff;
			wire [31:0] cnt_inc = cnt_r[gi] + step;
			// R11: wrap on reaching limit
			wire wrap = cyc_en && !bad_cyc && (cnt_inc == cyc_r[gi]);
			dpc_pkg::dpc_state_t st_nxt;
			logic [31:0] cnt_nxt;

			// R8: enable rise arms, start runs, enable drop stops
			always_comb begin
				st_nxt = st_r[gi];
				case (st_r[gi])
					dpc_pkg::DPC_IDLE: begin
						if (en && !en_prev_r) begin
							st_nxt = dpc_pkg::DPC_ARMED;
						end
					end
					dpc_pkg::DPC_ARMED: begin
						if (!en) begin
							st_nxt = dpc_pkg::DPC_IDLE;
						end else if (bad_cyc) begin
							st_nxt = dpc_pkg::DPC_FAULT;
						end else if (ctl[`DPC_CTRL_START]) begin
							st_nxt = dpc_pkg::DPC_RUN;
						end
					end
					dpc_pkg::DPC_RUN: begin
						if (!en) begin
							st_nxt = dpc_pkg::DPC_IDLE;
						end else if (bad_cyc) begin
							st_nxt = dpc_pkg::DPC_FAULT;
						end else if (!ctl[`DPC_CTRL_START]) begin
							st_nxt = dpc_pkg::DPC_ARMED;
						end
					end
					dpc_pkg::DPC_FAULT: begin
						// only a fresh enable cycle leaves the fault
						if (!en) begin
							st_nxt = dpc_pkg::DPC_IDLE;
						end
					end
					default: st_nxt = dpc_pkg::DPC_IDLE;
				endcase
			end

			// count priority: clear, preload, external clear, pulse
			always_comb begin
				cnt_nxt = cnt_r[gi];
				// R9: clear holds zero
				if (ctl[`DPC_CTRL_CLEAR]) begin
					cnt_nxt = 32'h0000_0000;
				// R12: preload held while strobe high
				end else if (pre_on) begin
					// load once on the rise; later edits of the value wait for the next strobe
					cnt_nxt = pre_prev_r ? cnt_r[gi] : pre_r[gi];
				// R10: external rising edge zeroes
				end else if (run && ext_rise) begin
					cnt_nxt = 32'h0000_0000;
				// R2: one step per synchronised edge
				end else if (run && pulse) begin
					cnt_nxt = wrap ? 32'h0000_0000 : cnt_inc;
				end
			end

			// R3: each instance only touched by its own writes
			always_ff @(posedge clk_sys_i) begin
				if (!rst_n_i) begin
					sel_r[gi] <= `DPC_RST_WORD;
					ctrl_r[gi] <= `DPC_RST_WORD;
					cyc_r[gi] <= `DPC_RST_WORD;
					pre_r[gi] <= `DPC_RST_WORD;
					imsk_r[gi] <= 3'h0;
				end else if (wr_me) begin
					case (wr_off)
						5'(`DPC_OFF_SEL): sel_r[gi] <= lane_merge(sel_r[gi], wdata_r, wstrb_r) & 32'h0000_00ff;
						5'(`DPC_OFF_CTRL): ctrl_r[gi] <= lane_merge(ctrl_r[gi], wdata_r, wstrb_r) & 32'h0000_007f;
						5'(`DPC_OFF_CYCLE): cyc_r[gi] <= lane_merge(cyc_r[gi], wdata_r, wstrb_r);
						5'(`DPC_OFF_PRELOAD): pre_r[gi] <= lane_merge(pre_r[gi], wdata_r, wstrb_r);
						5'(`DPC_OFF_IRQ_MASK): imsk_r[gi] <= wdata_r[2:0];
						default: ;
					endcase
				end
			end

			// R5: live signed count and state
			always_ff @(posedge clk_sys_i) begin
				if (!rst_n_i) begin
					cnt_r[gi] <= 32'h0000_0000;
					st_r[gi] <= dpc_pkg::DPC_IDLE;
					en_prev_r <= 1'b0;
					pre_prev_r <= 1'b0;
					code_r[gi] <= `DPC_FAULT_NONE;
				end else begin
					cnt_r[gi] <= cnt_nxt;
					st_r[gi] <= st_nxt;
					en_prev_r <= en;
					pre_prev_r <= pre_on;
					// R7: latch fault code on entering fault
					if (st_nxt == dpc_pkg::DPC_FAULT && st_r[gi] != dpc_pkg::DPC_FAULT) begin
						code_r[gi] <= `DPC_FAULT_CYCLE;
					end else if (st_nxt == dpc_pkg::DPC_IDLE) begin
						code_r[gi] <= `DPC_FAULT_NONE;
					end
				end
			end

			// sticky events: set wins over write-one-clear
			wire [2:0] ev = {st_nxt == dpc_pkg::DPC_FAULT && st_r[gi] != dpc_pkg::DPC_FAULT,
				run && ext_rise && !ctl[`DPC_CTRL_CLEAR] && !pre_on,
				run && pulse && wrap && !ctl[`DPC_CTRL_CLEAR] && !pre_on && !ext_rise};
			wire [2:0] w1c = (wr_me && wr_off == 5'(`DPC_OFF_IRQ_STAT) && wstrb_r[0]) ? wdata_r[2:0] : 3'h0;
			always_ff @(posedge clk_sys_i) begin
				if (!rst_n_i) begin
					ist_r[gi] <= 3'h0;
				end else begin
					ist_r[gi] <= (ist_r[gi] & ~w1c) | ev;
				end
			end
			assign irq_vec[gi] = |(ist_r[gi] & imsk_r[gi]);
		end
	endgenerate

	// ---------------------------------------------------------------
	// read mux
	// ---------------------------------------------------------------
	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		if (rd_bank_ok) begin
			case (rd_off)
				5'(`DPC_OFF_SEL): rd_word = sel_r[rd_idx];
				5'(`DPC_OFF_CTRL): rd_word = ctrl_r[rd_idx];
				5'(`DPC_OFF_CYCLE): rd_word = cyc_r[rd_idx];
				5'(`DPC_OFF_PRELOAD): rd_word = pre_r[rd_idx];
				5'(`DPC_OFF_COUNT): rd_word = cnt_r[rd_idx];
				// R6: valid while running, error and code
				5'(`DPC_OFF_STAT): rd_word = {code_r[rd_idx], 14'h0000,
					st_r[rd_idx] == dpc_pkg::DPC_FAULT, st_r[rd_idx] == dpc_pkg::DPC_RUN};
				5'(`DPC_OFF_IRQ_STAT): rd_word = {29'h0000_0000, ist_r[rd_idx]};
				5'(`DPC_OFF_IRQ_MASK): rd_word = {29'h0000_0000, imsk_r[rd_idx]};
				default: rd_word = 32'h0000_0000;
			endcase
		end
	end
	wire rd_ok = rd_bank_ok && (rd_off[1:0] == 2'h0);
	wire wr_ok = wr_bank_ok && (wr_off[1:0] == 2'h0) && (wr_off != 5'(`DPC_OFF_COUNT))
		&& (wr_off != 5'(`DPC_OFF_STAT));

	// ---------------------------------------------------------------
	// axi4-lite slave
	// ---------------------------------------------------------------
	// write channels accepted in either order, response after both
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
			end
		end
	end

	// read: arready one cycle, rdata the cycle after
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
			irq_o <= 1'b0;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			irq_o <= |irq_vec;
		end
	end
endmodule
`default_nettype wire

// [hw/dpc_cfg.svh]
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define DPC_OFF_SEL 12'h000
`define DPC_OFF_CTRL 12'h004
`define DPC_OFF_CYCLE 12'h008
`define DPC_OFF_PRELOAD 12'h00c
`define DPC_OFF_COUNT 12'h010
`define DPC_OFF_STAT 12'h014
`define DPC_OFF_IRQ_STAT 12'h018
`define DPC_OFF_IRQ_MASK 12'h01c
// ---------------------------------------------------------------
// control word fields
// ---------------------------------------------------------------
`define DPC_CTRL_ENABLE 0
`define DPC_CTRL_START 1
`define DPC_CTRL_CLEAR 2
`define DPC_CTRL_EXT_CLR_EN 3
`define DPC_CTRL_DIR_UP 4
`define DPC_CTRL_CYC_EN 5
`define DPC_CTRL_PRELOAD 6
// ---------------------------------------------------------------
// status and interrupt bits
// ---------------------------------------------------------------
`define DPC_STAT_VALID 0
`define DPC_STAT_ERROR 1
`define DPC_IRQ_WRAP 0
`define DPC_IRQ_EXT_CLR 1
`define DPC_IRQ_FAULT 2
// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define DPC_RST_WORD 32'h0000_0000
`define DPC_CLK_HZ 10000000
`define DPC_MAX_PULSE_HZ 5000
// fault codes
`define DPC_FAULT_NONE 16'h0000
`define DPC_FAULT_SEL 16'h0001
`define DPC_FAULT_CYCLE 16'h0002
`endif

// [hw/dpc_pkg.sv]
`default_nettype none
package dpc_pkg;
	// per-instance run state
	typedef enum logic [1:0] {
		DPC_IDLE,
		DPC_ARMED,
		DPC_RUN,
		DPC_FAULT
	} dpc_state_t;
endpackage
`default_nettype wire

// [bench/dpc_pulse_counter_sva.sv]
`default_nettype none
module dpc_pulse_counter_chk #(
	parameter int NUM_CNT = 7
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// write side handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read side handshakes
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ---------------------------------------------------------------
	// bus answers, all judged on the system clock
	// ---------------------------------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	bvalid_hold_a:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	rdata_hold_a:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed while waiting");
	awready_pulse_a:
	assert property (s_axi_awready |=> !s_axi_awready) else $error("awready stuck");
	arready_pulse_a:
	assert property (s_axi_arready |=> !s_axi_arready) else $error("arready stuck");
	read_answer_a:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
	write_answer_a:
	assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
		else $error("no write response");
	bresp_legal_a:
	assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2}) else $error("bad bresp");
	bad_index_a:
	assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= NUM_CNT * 32
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("high index not refused");
	reset_quiet_a:
	assert property ($rose(rst_n_i) |-> !irq_o && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs busy after reset");
endmodule
bind dpc_pulse_counter dpc_pulse_counter_chk #(.NUM_CNT(NUM_CNT)) chk_u (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_o(irq_o));
`default_nettype wire

// [bench/dpc_pulse_src.sv]
`default_nettype none
module dpc_pulse_src #(
	parameter int PERIOD = 2000
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// pulse request
	input wire logic fire_i,
	input wire logic [3:0] ch_i,
	// terminals
	output logic [15:0] din_o,
	output logic busy_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt_r; // position inside the pulse period
	logic [3:0] ch_r; // terminal being pulsed
	// one pulse per 5 khz period, never faster
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'b0;
			cnt_r <= 16'h0;
			ch_r <= 4'h0;
		end else if (!busy_o && fire_i) begin
			busy_o <= 1'b1;
			cnt_r <= 16'h0;
			ch_r <= ch_i;
		end else if (busy_o) begin
			cnt_r <= cnt_r + 16'h1;
			// the low half keeps the next pulse a full period away
			if (cnt_r == 16'(PERIOD - 1)) busy_o <= 1'b0;
		end
	end
	// high half of the period on the chosen terminal, low otherwise
	assign din_o = (busy_o && cnt_r < 16'(PERIOD / 2)) ? (16'h1 << ch_r) : 16'h0;
endmodule
`default_nettype wire

// [bench/test_digital_input_pulse_counter.sv]
`include "dpc_cfg.svh"
`default_nettype none
module test_digital_input_pulse_counter;
	timeunit 1ns;
	timeprecision 1ns;
	// ---------------------------------------------------------------
	// stimulus and wiring
	// ---------------------------------------------------------------
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, irq, busy;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] din;
	logic fire = 1'b0;
	logic [3:0] ch = 4'h0;
	logic [15:0] seed = 16'h7774; // fixed start of the lfsr
	logic [31:0] pv [7]; // preload per instance
	logic [31:0] expv;
	logic [3:0] s;
	int bad_count = 0, samples_checked = 0, cyc = 0;
	dpc_pulse_counter #(.NUM_CNT(7), .NUM_IN(16)) dut_u (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .din_i(din), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq_o(irq));
	dpc_pulse_src #(.PERIOD(2000)) src_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.fire_i(fire), .ch_i(ch), .din_o(din), .busy_o(busy));
	initial forever #50 clk_sys_i = ~clk_sys_i;
	// hang guard, pulses alone need about 24000 cycles
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			results();
		end
	end
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [11:0] ra(input int i, input logic [11:0] off);
		return 12'(i * 32) + off;
	endfunction
	// expected count after one pulse, wrap replaces the limit by zero
	function automatic logic [31:0] step(input logic [31:0] c, input logic up, input logic wrap,
		input logic [31:0] lim);
		logic [31:0] n;
		n = up ? c + 32'h1 : c - 32'h1;
		return (wrap && n == lim) ? 32'h0 : n;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk_sys_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk_sys_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] er);
		@(posedge clk_sys_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk_sys_i);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		chk(rdata & m, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	// one pulse on a terminal, returns once the partner's period is over
	task automatic pulse(input logic [3:0] c);
		@(posedge clk_sys_i);
		fire <= 1'b1;
		ch <= c;
		@(posedge clk_sys_i);
		fire <= 1'b0;
		@(posedge clk_sys_i);
		while (busy) @(posedge clk_sys_i);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rchk(12'h0e0, 32'h0, 32'hffffffff, 2'h2);
		wr(ra(0, `DPC_OFF_COUNT), 32'h5, 2'h2);
		rchk(ra(0, `DPC_OFF_CTRL), `DPC_RST_WORD, 32'hffffffff, 2'h0);
		rchk(ra(0, `DPC_OFF_COUNT), 32'h0, 32'hffffffff, 2'h0);
		$display("reset and refusal test done");
		// random preloads, each instance on its own
		for (int i = 0; i < 7; i++) begin
			seed = lfsr(seed);
			pv[i] = {seed, ~seed};
			wr(ra(i, `DPC_OFF_PRELOAD), pv[i], 2'h0);
			wr(ra(i, `DPC_OFF_CTRL), 32'h40, 2'h0);
			wr(ra(i, `DPC_OFF_CTRL), 32'h0, 2'h0);
		end
		for (int i = 0; i < 7; i++) rchk(ra(i, `DPC_OFF_COUNT), pv[i], '1, 2'h0);
		wr(ra(3, `DPC_OFF_CTRL), 32'h04, 2'h0);
		rchk(ra(3, `DPC_OFF_COUNT), 32'h0, 32'hffffffff, 2'h0);
		rchk(ra(4, `DPC_OFF_COUNT), pv[4], 32'hffffffff, 2'h0);
		wr(ra(3, `DPC_OFF_CTRL), 32'h0, 2'h0);
		$display("preload and clear test done");
		// counting on a random source, up then down
		s = seed[3:0];
		wr(ra(2, `DPC_OFF_SEL), {24'h0, s ^ 4'h8, s}, 2'h0);
		wr(ra(2, `DPC_OFF_CTRL), 32'h01, 2'h0);
		pulse(s);
		rchk(ra(2, `DPC_OFF_COUNT), pv[2], 32'hffffffff, 2'h0);
		wr(ra(2, `DPC_OFF_CTRL), 32'h13, 2'h0);
		rchk(ra(2, `DPC_OFF_STAT), 32'h1, 32'h3, 2'h0);
		expv = pv[2];
		for (int k = 0; k < 5; k++) begin
			if (k == 3) wr(ra(2, `DPC_OFF_CTRL), 32'h03, 2'h0);
			pulse(s);
			expv = step(expv, k < 3, 1'b0, 32'h0);
			rchk(ra(2, `DPC_OFF_COUNT), expv, 32'hffffffff, 2'h0);
		end
		$display("counting test done");
		// cyclic wrap with its interrupt
		wr(ra(2, `DPC_OFF_CTRL), 32'h17, 2'h0);
		// a pulse while clear is held must leave the count at zero
		pulse(s);
		rchk(ra(2, `DPC_OFF_COUNT), 32'h0, 32'hffffffff, 2'h0);
		wr(ra(2, `DPC_OFF_CYCLE), 32'h2, 2'h0);
		wr(ra(2, `DPC_OFF_IRQ_MASK), 32'h1, 2'h0);
		wr(ra(2, `DPC_OFF_CTRL), 32'h33, 2'h0);
		expv = 32'h0;
		repeat (2) begin
			pulse(s);
			expv = step(expv, 1'b1, 1'b1, 32'h2);
			rchk(ra(2, `DPC_OFF_COUNT), expv, 32'hffffffff, 2'h0);
		end
		rchk(ra(2, `DPC_OFF_IRQ_STAT), 32'h1, 32'h1, 2'h0);
		chk({31'h0, irq}, 32'h1);
		wr(ra(2, `DPC_OFF_IRQ_MASK), 32'h0, 2'h0);
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, irq}, 32'h0);
		wr(ra(2, `DPC_OFF_IRQ_STAT), 32'h1, 2'h0);
		rchk(ra(2, `DPC_OFF_IRQ_STAT), 32'h0, 32'h1, 2'h0);
		$display("cyclic test done");
		// preload held, then external clear on the other terminal
		wr(ra(2, `DPC_OFF_PRELOAD), 32'h7, 2'h0);
		wr(ra(2, `DPC_OFF_CTRL), 32'h5b, 2'h0);
		pulse(s);
		rchk(ra(2, `DPC_OFF_COUNT), 32'h7, 32'hffffffff, 2'h0);
		wr(ra(2, `DPC_OFF_CTRL), 32'h1b, 2'h0);
		pulse(s);
		rchk(ra(2, `DPC_OFF_COUNT), 32'h8, 32'hffffffff, 2'h0);
		pulse(s ^ 4'h8);
		rchk(ra(2, `DPC_OFF_COUNT), 32'h0, 32'hffffffff, 2'h0);
		// wrap bit was cleared above, so only the external clear event stands
		rchk(ra(2, `DPC_OFF_IRQ_STAT), 32'h2, 32'h3, 2'h0);
		$display("external clear test done");
		// wrap asked for with a zero limit
		wr(ra(5, `DPC_OFF_CTRL), 32'h01, 2'h0);
		wr(ra(5, `DPC_OFF_CTRL), 32'h23, 2'h0);
		rchk(ra(5, `DPC_OFF_STAT), 32'h00020002, 32'hffff0002, 2'h0);
		rchk(ra(5, `DPC_OFF_IRQ_STAT), 32'h4, 32'h7, 2'h0);
		$display("fault test done");
		results();
	end
endmodule
`default_nettype wire
